// ===== src/cssq_top.sv
// Clock source decode, reset time-out, start-up count and clock domain enables.
//
// Local design decisions: the address map and the APB slave port.
`timescale 1ns/1ps
// What this block does
// - Fuse codes 1111-1000 low power, 0111-0110 full swing, 0101-0100 low freq crystal.
// - Code 0011 picks 128kHz RC, 0010 calibrated RC, 0000 external; 0001 reserved.
// - Every fuse bit reads one as unprogrammed and zero as programmed.
// - Default fuses select calibrated RC, divide by eight, startup field 10.
// - Internal reset stays after other reset sources release, for a further time-out.
// - Time-out counts watchdog oscillator cycles: zero, 512 or 8192.
// - Counter of selected oscillator cycles holds reset until the start-up count ends.
// - Reset start applies time-out and start-up; power-down wake applies start-up only.
// - In low power crystal mode upper three select bits give the frequency range.
// - Low select bit plus startup fuses choose 258, 1K or 16K cycle start-up.
// - Slow rising power adds 14 cycles plus long time-out; fast adds short time-out.
// - Brown-out detector settings add only 14 cycles with no time-out.
// - Programmed divide fuse divides the internal clock by eight for the system.
// - Halting the core clock stops all core operation.
// - Asynchronous wake inputs work while the peripheral clock is halted.
// - Program memory clock runs whenever the core clock runs.
// - Async timer clock comes from its own crystal and runs during sleep.
// - Converter clock has its own domain and runs in ADC noise reduction sleep while core and peripherals halt.
module cssq_top #(
  parameter logic [15:0] TOUT_8K_CYCLES  = 16'h2000,
  parameter logic [15:0] START_16K_CYCLES = 16'h4000,
  parameter logic [15:0] START_32K_CYCLES = 16'h8000
) (
  input  wire logic                      pclk,
  input  wire logic                      presetn,
  input  wire logic                      psel,
  input  wire logic                      penable,
  input  wire logic                      pwrite,
  input  wire logic [7:0]                paddr,
  input  wire logic [31:0]               pwdata,
  output logic [31:0]                    prdata,
  output logic                           pready,
  output logic                           pslverr,
  input  wire cssq_pkg::cssq_pin_type    pins_in,
  output logic                           internal_reset_n,
  output logic                           core_halted,
  output cssq_pkg::cssq_clk_en_type      clk_en
);

  logic [11:0]                pin_vec;
  logic [11:0]                sync1_reg;
  logic [11:0]                sync2_reg;
  logic [11:0]                sync3_reg;
  logic [11:0]                stable_reg;
  logic [11:0]                rise;
  logic [5:0]                 osc_rise;
  logic                       other_rst;
  logic                       wdt_tick;
  logic                       async_tick;
  logic                       wake;
  logic                       sel_tick;
  logic                       sys_tick;
  logic [6:0]                 fuse_reg;
  logic [1:0]                 ctrl_reg;
  cssq_pkg::cssq_cfg_type     cfg_reg;
  cssq_pkg::cssq_cfg_type     dec_next;
  cssq_pkg::cssq_state_type   state_reg;
  logic [15:0]                cnt_reg;
  logic [15:0]                target;
  logic                       from_reset_reg;
  logic [2:0]                 div_reg;
  logic                       wr_en;
  logic                       setup;
  logic                       hit;
  logic [31:0]                rd_value;

  // Time-out length in watchdog cycles for a power condition: 0 brown-out, 1 fast, 2 slow.
  function automatic logic [15:0] tout_of(input logic [1:0] kind);
    logic [15:0] t;
    t = cssq_pkg::TOUT_0;
    if (kind == 2'h1) begin
      t = cssq_pkg::TOUT_512;
    end else if (kind == 2'h2) begin
      t = TOUT_8K_CYCLES;
    end
    return t;
  endfunction

  // Fuse decode; programmed bits are zero throughout.
  function automatic cssq_pkg::cssq_cfg_type decode(input logic [6:0] f);
    cssq_pkg::cssq_cfg_type c;
    logic [3:0] ck;
    logic [1:0] startup_time_fuses;
    logic [2:0] sel;
    ck  = f[cssq_pkg::FUSE_SRC_LSB +: 4];
    startup_time_fuses = f[cssq_pkg::FUSE_SUT_LSB +: 2];
    sel = {ck[0], startup_time_fuses};
    c.src      = cssq_pkg::SRC_RC8M;
    c.lp_range = 3'h0;
    c.tout     = tout_of(startup_time_fuses);
    c.start    = cssq_pkg::CK_EXT;
    c.div8     = ~f[cssq_pkg::FUSE_DIV_BIT];
    c.invalid  = 1'b0;
    if (ck[3] || ck[3:1] == 3'h3) begin
      c.src      = ck[3] ? cssq_pkg::SRC_LP : cssq_pkg::SRC_FS;
      c.lp_range = ck[3] ? ck[3:1] : 3'h0;
      case (sel)
        3'h0: begin c.start = cssq_pkg::CK_258; c.tout = tout_of(2'h1); end
        3'h1: begin c.start = cssq_pkg::CK_258; c.tout = tout_of(2'h2); end
        3'h2: begin c.start = cssq_pkg::CK_1K;  c.tout = tout_of(2'h0); end
        3'h3: begin c.start = cssq_pkg::CK_1K;  c.tout = tout_of(2'h1); end
        3'h4: begin c.start = cssq_pkg::CK_1K;  c.tout = tout_of(2'h2); end
        3'h5: begin c.start = START_16K_CYCLES; c.tout = tout_of(2'h0); end
        3'h6: begin c.start = START_16K_CYCLES; c.tout = tout_of(2'h1); end
        default: begin c.start = START_16K_CYCLES; c.tout = tout_of(2'h2); end
      endcase
    end else if (ck[3:1] == 3'h2) begin
      c.src   = cssq_pkg::SRC_LF;
      c.start = ck[0] ? START_32K_CYCLES : cssq_pkg::CK_1K;
      c.invalid = (startup_time_fuses == 2'h3);
    end else if (ck == 4'h3) begin
      c.src     = cssq_pkg::SRC_RC128;
      c.invalid = (startup_time_fuses == 2'h3);
    end else if (ck == 4'h2) begin
      c.src     = cssq_pkg::SRC_RC8M;
      c.invalid = (startup_time_fuses == 2'h3);
    end else if (ck == 4'h0) begin
      c.src     = cssq_pkg::SRC_EXT;
      c.invalid = (startup_time_fuses == 2'h3);
    end else begin
      c.invalid = 1'b1;
    end
    // A bad code gets the internal RC, full time-out and the slow divided clock, which
    // works on any board whatever crystal is fitted.
    if (c.invalid) begin
      c.src      = cssq_pkg::SRC_RC8M;
      c.lp_range = 3'h0;
      c.start    = cssq_pkg::CK_EXT;
      c.tout     = tout_of(2'h2);
      c.div8     = 1'b1;
    end
    return c;
  endfunction

  localparam cssq_pkg::cssq_cfg_type CFG_RESET = decode(cssq_pkg::FUSE_RESET);

  // Pin synchroniser: a level counts once stages two and three agree.
  assign pin_vec = pins_in;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_reg  <= cssq_pkg::SYNC_RESET;
      sync2_reg  <= cssq_pkg::SYNC_RESET;
      sync3_reg  <= cssq_pkg::SYNC_RESET;
      stable_reg <= cssq_pkg::SYNC_RESET;
    end else begin
      sync1_reg  <= pin_vec;
      sync2_reg  <= sync1_reg;
      sync3_reg  <= sync2_reg;
      stable_reg <= (sync2_reg & sync3_reg) | (stable_reg & (sync2_reg ^ sync3_reg));
    end
  end

  assign rise       = sync2_reg & sync3_reg & ~stable_reg;
  assign osc_rise   = rise[5:0];
  assign other_rst  = stable_reg[cssq_pkg::PIN_RST];
  assign wdt_tick   = rise[cssq_pkg::PIN_WDT];
  assign async_tick = rise[cssq_pkg::PIN_ASY];
  assign wake       = |rise[cssq_pkg::PIN_W_MSB:cssq_pkg::PIN_W_LSB];
  assign sel_tick   = osc_rise[cfg_reg.src];
  assign sys_tick   = sel_tick && (!cfg_reg.div8 || div_reg == 3'h7);
  assign dec_next   = decode(fuse_reg);
  assign target     = cfg_reg.start + (from_reset_reg ? cssq_pkg::CK_14 : 16'h0000);

  // Fuses are latched when the outside reset lets go, so a later write waits for the next
  // reset sequence instead of switching the source under a running core.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_reg <= CFG_RESET;
    end else if (state_reg == cssq_pkg::ST_HOLD && !other_rst) begin
      cfg_reg <= dec_next;
    end
  end

  // Start-up sequencer.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg        <= cssq_pkg::ST_HOLD;
      cnt_reg          <= 16'h0000;
      from_reset_reg   <= 1'b1;
      internal_reset_n <= 1'b0;
    end else if (other_rst) begin
      state_reg        <= cssq_pkg::ST_HOLD;
      cnt_reg          <= 16'h0000;
      from_reset_reg   <= 1'b1;
      internal_reset_n <= 1'b0;
    end else begin
      case (state_reg)
        cssq_pkg::ST_HOLD: begin
          cnt_reg        <= 16'h0000;
          from_reset_reg <= 1'b1;
          if (dec_next.tout == cssq_pkg::TOUT_0) begin
            state_reg <= cssq_pkg::ST_STARTUP;
          end else begin
            state_reg <= cssq_pkg::ST_TIMEOUT;
          end
        end
        cssq_pkg::ST_TIMEOUT: begin
          if (wdt_tick) begin
            if (cnt_reg == cfg_reg.tout - 16'h0001) begin
              cnt_reg   <= 16'h0000;
              state_reg <= cssq_pkg::ST_STARTUP;
            end else begin
              cnt_reg <= cnt_reg + 16'h0001;
            end
          end
        end
        cssq_pkg::ST_STARTUP: begin
          if (sel_tick) begin
            if (cnt_reg == target - 16'h0001) begin
              cnt_reg          <= 16'h0000;
              state_reg        <= cssq_pkg::ST_RUN;
              internal_reset_n <= 1'b1;
            end else begin
              cnt_reg <= cnt_reg + 16'h0001;
            end
          end
        end
        cssq_pkg::ST_RUN: begin
          if (ctrl_reg == cssq_pkg::SLEEP_PD) begin
            state_reg <= cssq_pkg::ST_SLEEP;
          end else if (ctrl_reg == cssq_pkg::SLEEP_ADC) begin
            state_reg <= cssq_pkg::ST_ADCNR;
          end
        end
        cssq_pkg::ST_ADCNR: begin
          if (wake) begin
            state_reg <= cssq_pkg::ST_RUN;
          end
        end
        cssq_pkg::ST_SLEEP: begin
          // The oscillator was stopped, so it must settle again, but supply is assumed good.
          if (wake) begin
            state_reg      <= cssq_pkg::ST_STARTUP;
            cnt_reg        <= 16'h0000;
            from_reset_reg <= 1'b0;
          end
        end
        default: begin
          state_reg <= cssq_pkg::ST_HOLD;
        end
      endcase
    end
  end

  // System clock prescaler on the selected oscillator.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_reg <= 3'h0;
    end else if (state_reg == cssq_pkg::ST_HOLD) begin
      div_reg <= 3'h0;
    end else if (sel_tick) begin
      div_reg <= div_reg + 3'h1;
    end
  end

  // Clock domain enables.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clk_en <= '0;
    end else begin
      clk_en.core_clock_domain       <= sys_tick && state_reg == cssq_pkg::ST_RUN;
      clk_en.program_memory_clock    <= sys_tick && state_reg == cssq_pkg::ST_RUN;
      clk_en.peripheral_clock_domain <= sys_tick && state_reg == cssq_pkg::ST_RUN;
      clk_en.converter_clock_domain  <= sys_tick && (state_reg == cssq_pkg::ST_RUN ||
                                        state_reg == cssq_pkg::ST_ADCNR);
      clk_en.async_timer_clock       <= async_tick;
    end
  end

  assign core_halted = (state_reg != cssq_pkg::ST_RUN);

  // APB slave, zero wait states.
  assign pready = 1'b1;
  assign setup  = psel && !penable;
  assign wr_en  = psel && penable && pwrite;
  assign hit    = (paddr == cssq_pkg::ADDR_FUSE) || (paddr == cssq_pkg::ADDR_CTRL) ||
                  (paddr == cssq_pkg::ADDR_STATUS) || (paddr == cssq_pkg::ADDR_COUNT);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fuse_reg <= cssq_pkg::FUSE_RESET;
    end else if (wr_en && paddr == cssq_pkg::ADDR_FUSE) begin
      fuse_reg <= pwdata[6:0];
    end
  end

  // A software write wins over the hardware clear on wake, so a new request is never lost.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg <= cssq_pkg::SLEEP_NONE;
    end else if (wr_en && paddr == cssq_pkg::ADDR_CTRL) begin
      ctrl_reg <= pwdata[1:0];
    end else if (wake && (state_reg == cssq_pkg::ST_SLEEP ||
                          state_reg == cssq_pkg::ST_ADCNR)) begin
      ctrl_reg <= cssq_pkg::SLEEP_NONE;
    end
  end

  always_comb begin
    rd_value = 32'h0000_0000;
    if (paddr == cssq_pkg::ADDR_FUSE) begin
      rd_value = {25'h000_0000, fuse_reg};
    end else if (paddr == cssq_pkg::ADDR_CTRL) begin
      rd_value = {30'h0000_0000, ctrl_reg};
    end else if (paddr == cssq_pkg::ADDR_STATUS) begin
      rd_value = {20'h0_0000, internal_reset_n, cfg_reg.lp_range, cfg_reg.invalid,
                  cfg_reg.div8, cfg_reg.src, state_reg};
    end else if (paddr == cssq_pkg::ADDR_COUNT) begin
      rd_value = {16'h0000, cnt_reg};
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (setup) begin
      prdata  <= pwrite ? 32'h0000_0000 : rd_value;
      pslverr <= !hit;
    end
  end

  // Checks.
  sequence s_released;
    state_reg == cssq_pkg::ST_RUN ##0 internal_reset_n;
  endsequence

  sequence s_startup_begun;
    state_reg == cssq_pkg::ST_STARTUP ##0 cnt_reg == 16'h0000;
  endsequence

  property p_reset_held;
    @(posedge pclk) disable iff (!presetn)
    (state_reg == cssq_pkg::ST_HOLD || state_reg == cssq_pkg::ST_TIMEOUT) |-> !internal_reset_n;
  endproperty
  a_reset_held: assert property (p_reset_held) else $error("reset released early");
  property p_timeout_ends;
    @(posedge pclk) disable iff (!presetn)
    state_reg == cssq_pkg::ST_TIMEOUT && wdt_tick && !other_rst &&
    cnt_reg == cfg_reg.tout - 16'h0001 |=> s_startup_begun;
  endproperty
  a_timeout_ends: assert property (p_timeout_ends) else $error("time-out end wrong");
  property p_release;
    @(posedge pclk) disable iff (!presetn)
    state_reg == cssq_pkg::ST_STARTUP && sel_tick && !other_rst &&
    cnt_reg == target - 16'h0001 |=> s_released;
  endproperty
  a_release: assert property (p_release) else $error("start-up end wrong");
  property p_run_only_after_count;
    @(posedge pclk) disable iff (!presetn)
    $rose(internal_reset_n) |-> $past(state_reg) == cssq_pkg::ST_STARTUP &&
                                 $past(cnt_reg) == $past(target) - 16'h0001;
  endproperty
  a_run_only_after_count: assert property (p_run_only_after_count) else $error("early run");
  property p_wake_no_timeout;
    @(posedge pclk) disable iff (!presetn)
    state_reg == cssq_pkg::ST_SLEEP && wake && !other_rst |=> s_startup_begun ##0 !from_reset_reg;
  endproperty
  a_wake_no_timeout: assert property (p_wake_no_timeout) else $error("wake path wrong");
  property p_div8;
    @(posedge pclk) disable iff (!presetn)
    clk_en.core_clock_domain |-> $past(sel_tick) && (!cfg_reg.div8 || $past(div_reg) == 3'h7);
  endproperty
  a_div8: assert property (p_div8) else $error("core enable not divided");
  property p_core_halt;
    @(posedge pclk) disable iff (!presetn)
    state_reg != cssq_pkg::ST_RUN |=> !clk_en.core_clock_domain && !clk_en.peripheral_clock_domain;
  endproperty
  a_core_halt: assert property (p_core_halt) else $error("core clock while halted");
  property p_flash_core;
    @(posedge pclk) disable iff (!presetn)
    clk_en.program_memory_clock == clk_en.core_clock_domain;
  endproperty
  a_flash_core: assert property (p_flash_core) else $error("flash clock apart");
  property p_adc_domain;
    @(posedge pclk) disable iff (!presetn)
    state_reg == cssq_pkg::ST_ADCNR && sys_tick |=> clk_en.converter_clock_domain;
  endproperty
  a_adc_domain: assert property (p_adc_domain) else $error("converter clock lost");

  property p_async_sleep;
    @(posedge pclk) disable iff (!presetn)
    state_reg == cssq_pkg::ST_SLEEP && async_tick |=> clk_en.async_timer_clock;
  endproperty
  a_async_sleep: assert property (p_async_sleep) else $error("async timer stopped");

  property p_fallback;
    @(posedge pclk) disable iff (!presetn)
    state_reg == cssq_pkg::ST_HOLD && !other_rst && fuse_reg[3:0] == 4'h1 |=>
    cfg_reg.src == cssq_pkg::SRC_RC8M && cfg_reg.invalid;
  endproperty
  a_fallback: assert property (p_fallback) else $error("reserved code not caught");

endmodule // cssq_top

// ===== pkg/cssq_pkg.sv
// Shared constants, types and register map of the clock source start-up sequencer.
package cssq_pkg;

  // Register byte offsets on the APB slave.
  localparam logic [7:0] ADDR_FUSE   = 8'h00;
  localparam logic [7:0] ADDR_CTRL   = 8'h04;
  localparam logic [7:0] ADDR_STATUS = 8'h08;
  localparam logic [7:0] ADDR_COUNT  = 8'h0C;

  // Fuse register layout; a one means unprogrammed, a zero programmed.
  localparam int FUSE_SRC_LSB = 0;
  localparam int FUSE_SUT_LSB = 4;
  localparam int FUSE_DIV_BIT = 6;
  localparam logic [6:0] FUSE_RESET = 7'h22;

  // Sleep request codes held in the control register.
  localparam logic [1:0] SLEEP_NONE = 2'h0;
  localparam logic [1:0] SLEEP_ADC  = 2'h1;
  localparam logic [1:0] SLEEP_PD   = 2'h2;

  // Cycle counts that stay below the parameter threshold.
  localparam logic [15:0] CK_EXT  = 16'h0006;
  localparam logic [15:0] CK_14   = 16'h000E;
  localparam logic [15:0] CK_258  = 16'h0102;
  localparam logic [15:0] CK_1K   = 16'h0400;
  localparam logic [15:0] TOUT_0  = 16'h0000;
  localparam logic [15:0] TOUT_512 = 16'h0200;

  // Bit positions inside the pin group.
  localparam int PIN_WDT   = 6;
  localparam int PIN_ASY   = 7;
  localparam int PIN_RST   = 8;
  localparam int PIN_W_LSB = 9;
  localparam int PIN_W_MSB = 11;
  // Synchroniser value after reset: the other reset source counts as still holding, so no
  // time-out can start before that pin has really been seen low.
  localparam logic [11:0] SYNC_RESET = 12'h100;

  typedef enum logic [2:0] {
    SRC_LP   = 3'b000,
    SRC_FS   = 3'b001,
    SRC_LF   = 3'b010,
    SRC_RC128 = 3'b011,
    SRC_RC8M = 3'b100,
    SRC_EXT  = 3'b101
  } cssq_src_type;

  typedef enum logic [2:0] {
    ST_HOLD    = 3'b000,
    ST_TIMEOUT = 3'b001,
    ST_STARTUP = 3'b010,
    ST_RUN     = 3'b011,
    ST_ADCNR   = 3'b100,
    ST_SLEEP   = 3'b101
  } cssq_state_type;

  typedef struct packed {
    cssq_src_type src;
    logic [2:0]   lp_range;
    logic [15:0]  tout;
    logic [15:0]  start;
    logic         div8;
    logic         invalid;
  } cssq_cfg_type;

  // Asynchronous pins, all sampled through the three-stage synchroniser.
  typedef struct packed {
    logic       addr_match;
    logic       start_cond;
    logic       ext_int;
    logic       other_reset;
    logic       async_xtal;
    logic       wdt_osc;
    logic [5:0] osc;
  } cssq_pin_type;

  typedef struct packed {
    logic core_clock_domain;
    logic peripheral_clock_domain;
    logic program_memory_clock;
    logic async_timer_clock;
    logic converter_clock_domain;
  } cssq_clk_en_type;

endpackage

// ===== sim/cssq_osc_model.sv
// Behavioural oscillators, reset source and wake events around the sequencer.
`timescale 1ns/1ps
module cssq_osc_model (
  input  wire logic              pclk,
  input  wire logic              rst_hold,
  input  wire logic [2:0]        wake,
  output cssq_pkg::cssq_pin_type pins
);
  int unsigned cyc = 0;

  always @(posedge pclk) begin
    cyc <= cyc + 1;
  end

  // Every source runs slow against pclk so that no edge is lost in the synchroniser.
  always_comb begin
    pins.osc         = {6{cyc[1]}};
    pins.wdt_osc     = cyc[2];
    pins.async_xtal  = cyc[3];
    pins.other_reset = rst_hold;
    {pins.addr_match, pins.start_cond, pins.ext_int} = wake;
  end
endmodule // cssq_osc_model

// ===== sim/clock_source_startup_sequencer_tb.sv
// Self-checking bench for the clock source start-up sequencer.
`timescale 1ns/1ps
module clock_source_startup_sequencer_tb;
  logic                      pclk, presetn, psel, penable, pwrite, err;
  logic                      pready, pslverr, internal_reset_n, core_halted, rst_hold;
  logic [7:0]                paddr;
  logic [31:0]               pwdata, prdata, rd;
  logic [2:0]                wake;
  cssq_pkg::cssq_pin_type    pins_in;
  cssq_pkg::cssq_clk_en_type clk_en;
  int                        fails = 0;
  int                        tests_run = 0;
  int                        core_cnt = 0;
  int                        conv_cnt = 0;
  int                        asy_cnt = 0;
  int                        per_cnt = 0;
  // Fuse byte, expected source and expected release time in pclk cycles.
  // Bytes 41 and 74 hold reserved codes and must fall back to the divided internal RC.
  logic [6:0]                fz[15] = '{7'h5F, 7'h68, 7'h57, 7'h66, 7'h45, 7'h44,
                                        7'h43, 7'h42, 7'h40, 7'h50, 7'h60, 7'h41,
                                        7'h7F, 7'h5E, 7'h74};
  logic [2:0]                sx[15] = '{3'h0, 3'h0, 3'h1, 3'h1, 3'h2, 3'h2,
                                        3'h3, 3'h4, 3'h5, 3'h5, 3'h5, 3'h4,
                                        3'h0, 3'h0, 3'h4};
  int                        tk[15] = '{184, 4152, 184, 4152, 312, 4152,
                                        80, 80, 80, 4176, 208, 208,
                                        312, 1216, 208};

  cssq_top #(.TOUT_8K_CYCLES(16'h0010), .START_16K_CYCLES(16'h0020),
             .START_32K_CYCLES(16'h0040)) dut_u (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .pins_in(pins_in), .internal_reset_n(internal_reset_n), .core_halted(core_halted),
    .clk_en(clk_en));

  cssq_osc_model osc_u (.pclk(pclk), .rst_hold(rst_hold), .wake(wake), .pins(pins_in));

  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end

  task automatic fail_msg(input string m);
    fails++;
    $display("FAIL t=%0t %s", $time, m);
  endtask

  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic chk32(input logic [31:0] got, input logic [31:0] exp, input string m);
    tests_run++;
    if (got !== exp) fail_msg(m);
  endtask

  task automatic chk_rng(input int got, input int lo, input int hi, input string m);
    tests_run++;
    if (got < lo || got > hi) fail_msg(m);
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      fail_msg("no pready");
      tally_and_finish();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wait_halt(input logic v, output int n);
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (core_halted !== v && n < 200);
    if (core_halted !== v) begin
      fail_msg("halt wait ran out");
      tally_and_finish();
    end
  endtask

  // Writes the fuses, pulses the other reset source and times the internal release.
  task automatic restart(input logic [31:0] fuse, output int n);
    apb(1'b1, cssq_pkg::ADDR_FUSE, fuse);
    rst_hold <= 1'b1;
    repeat (6) @(posedge pclk);
    rst_hold <= 1'b0;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (internal_reset_n !== 1'b1 && n < 6000);
    if (internal_reset_n !== 1'b1) begin
      fail_msg("release wait ran out");
      tally_and_finish();
    end
  endtask

  always @(posedge pclk) begin
    if (clk_en.core_clock_domain === 1'b1) core_cnt <= core_cnt + 1;
    if (clk_en.converter_clock_domain === 1'b1) conv_cnt <= conv_cnt + 1;
    if (clk_en.async_timer_clock === 1'b1) asy_cnt <= asy_cnt + 1;
    if (clk_en.peripheral_clock_domain === 1'b1) per_cnt <= per_cnt + 1;
    if (clk_en.core_clock_domain === 1'b1) chk32({31'h0, clk_en.program_memory_clock},
                                                32'h0000_0001, "flash clock idle");
  end

  initial begin
    repeat (100000) @(posedge pclk);
    fail_msg("run timeout");
    tally_and_finish();
  end

  initial begin
    int n, c0, a0, p0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    rst_hold = 1'b1;
    wake = 3'h0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, cssq_pkg::ADDR_FUSE, 32'h0000_0000);
    chk32(rd, 32'h0000_0022, "fuse reset value");
    apb(1'b0, cssq_pkg::ADDR_STATUS, 32'h0000_0000);
    chk32({20'h0, rd[11], 8'h0, rd[2:0]}, 32'h0000_0000, "held in reset");
    apb(1'b0, 8'h10, 32'h0000_0000);
    chk32({err, rd[30:0]}, 32'h8000_0000, "unmapped read");
    restart(32'h0000_0022, n);
    chk_rng(n, 202, 232, "default release time");
    apb(1'b0, cssq_pkg::ADDR_STATUS, 32'h0000_0000);
    chk32({20'h0, rd[11:0]}, 32'h0000_0863, "default status");
    c0 = core_cnt;
    p0 = per_cnt;
    repeat (320) @(posedge pclk);
    chk_rng(core_cnt - c0, 9, 11, "divided core clock");
    chk_rng(per_cnt - p0, 9, 11, "divided io clock");
    apb(1'b1, cssq_pkg::ADDR_CTRL, {30'h0, cssq_pkg::SLEEP_PD});
    wait_halt(1'b1, n);
    c0 = core_cnt;
    a0 = asy_cnt;
    repeat (100) @(posedge pclk);
    chk_rng(core_cnt - c0, 0, 0, "core clock in sleep");
    chk_rng(asy_cnt - a0, 1, 100, "timer clock in sleep");
    wake <= 3'b001;
    wait_halt(1'b0, n);
    chk_rng(n, 18, 40, "wake start-up only");
    wake <= 3'b000;
    apb(1'b0, cssq_pkg::ADDR_CTRL, 32'h0000_0000);
    chk32(rd, 32'h0000_0000, "sleep cleared on wake");
    apb(1'b1, cssq_pkg::ADDR_CTRL, {30'h0, cssq_pkg::SLEEP_ADC});
    wait_halt(1'b1, n);
    c0 = core_cnt;
    a0 = conv_cnt;
    p0 = per_cnt;
    repeat (100) @(posedge pclk);
    chk_rng(core_cnt - c0, 0, 0, "core clock in noise sleep");
    chk_rng(conv_cnt - a0, 1, 100, "converter clock");
    chk_rng(per_cnt - p0, 0, 0, "io clock in noise sleep");
    wake <= 3'b100;
    wait_halt(1'b0, n);
    chk_rng(n, 1, 12, "noise sleep wake");
    wake <= 3'b000;
    for (int i = 0; i < 15; i++) begin
      logic inv;
      inv = (fz[i] == 7'h41) || (fz[i] == 7'h74);
      restart({25'h0, fz[i]}, n);
      chk_rng(n, tk[i] - 6, tk[i] + 24, "release time");
      apb(1'b0, cssq_pkg::ADDR_STATUS, 32'h0000_0000);
      chk32({29'h0, rd[5:3]}, {29'h0, sx[i]}, "source");
      chk32({31'h0, rd[7]}, {31'h0, inv}, "invalid flag");
      chk32({31'h0, rd[6]}, {31'h0, !fz[i][6] || inv}, "divide flag");
      if (sx[i] == 3'h0) chk32({29'h0, rd[10:8]}, {29'h0, fz[i][3:1]}, "range");
    end
    restart(32'h0000_0040, n);
    c0 = core_cnt;
    repeat (320) @(posedge pclk);
    chk_rng(core_cnt - c0, 78, 82, "undivided core clock");
    tally_and_finish();
  end
endmodule // clock_source_startup_sequencer_tb
